/* rtl/fcs_mode_ctrl.sv */
// Purpose: mode control, status and gating for the loop clock source
// Assumes: all bus and stop inputs on i_ref_clk; status pins asynchronous
// Notes: outputs are enables for the analog clock tree, not clocks
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ns
module fcs_mode_ctrl
    import fcs_pkg::*;
(
    input wire logic i_ref_clk, // 20 MHz block clock
    input wire logic i_nrst, // async reset, active low
    input wire logic i_clk_en, // freezes all state when low
    input wire logic [1:0] i_addr, // register index
    input wire logic [7:0] i_wdata, // write data
    input wire logic i_wr, // write strobe
    input wire logic i_rd, // read strobe
    output logic [7:0] o_rdata, // read data, cycle after read
    input wire logic i_stop_req, // chip stop state, same clock
    input wire logic i_debug_active, // debug mode pin, async
    input wire logic i_osc_init_done, // oscillator init cycles done, async
    input wire logic i_ext_ref_ok, // divided external ref usable, async
    input wire logic i_loop_locked, // loop output usable, async
    input wire logic i_factory_fine_trim, // factory fine trim strap
    output fcs_gate_t o_gate, // clock tree enables
    output fcs_mode_t o_mode, // current operating state
    output logic [1:0] o_range_code, // loop range to analog
    output logic o_max_freq_finetune, // 32.768 kHz tuning to analog
    output logic [10:0] o_fll_factor, // loop multiplication factor
    output logic o_fine_trim, // internal reference fine trim
    output logic [2:0] o_ref_divider, // external reference divider code
    output logic [3:0] o_bus_div_factor // bus clock divide factor
);
    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    function automatic fcs_mode_t run_mode(input logic [1:0] src, input logic lp,
                                           input logic dbg, input logic ref_int);
        fcs_mode_t m;
        m = MODE_ENG_INT;
        case (src)
            SRC_INT: begin
                m = (lp && !dbg) ? MODE_BYP_INT_LP : MODE_BYP_INT;
            end
            SRC_EXT: begin
                m = (lp && !dbg) ? MODE_BYP_EXT_LP : MODE_BYP_EXT;
            end
            default: begin
                m = ref_int ? MODE_ENG_INT : MODE_ENG_EXT;
            end
        endcase
        return m;
    endfunction

    function automatic logic [1:0] mode_src(input fcs_mode_t m);
        logic [1:0] s;
        s = SRC_LOOP;
        case (m)
            MODE_BYP_INT, MODE_BYP_INT_LP: s = SRC_INT;
            MODE_BYP_EXT, MODE_BYP_EXT_LP: s = SRC_EXT;
            default: s = SRC_LOOP;
        endcase
        return s;
    endfunction

    function automatic logic uses_ext(input fcs_mode_t m);
        return (m == MODE_ENG_EXT) || (m == MODE_BYP_EXT) || (m == MODE_BYP_EXT_LP);
    endfunction

    function automatic logic [10:0] fll_factor(input logic [1:0] rng, input logic mx);
        logic [10:0] f;
        f = mx ? FACT_LOW_MX : FACT_LOW;
        case (rng)
            RANGE_MID: f = mx ? FACT_MID_MX : FACT_MID;
            RANGE_HIGH: f = mx ? FACT_HIGH_MX : FACT_HIGH;
            default: f = mx ? FACT_LOW_MX : FACT_LOW;
        endcase
        return f;
    endfunction

    function automatic fcs_gate_t gate_of(input fcs_mode_t m, input fcs_ctrl_t c);
        fcs_gate_t g;
        g = '0;
        g.main_sel = mode_src(m);
        g.int_ref_out_en = c.int_en;
        g.ext_src_on = c.ext_en;
        g.ext_ref_on = c.ext_en;
        g.loop_ref_int = (m == MODE_ENG_INT) || (m == MODE_BYP_INT) || (m == MODE_BYP_INT_LP);
        case (m)
            MODE_ENG_INT, MODE_BYP_INT: begin
                g.loop_en = 1'b1;
                g.local_clk_en = 1'b1;
                g.int_ref_on = 1'b1;
            end
            MODE_ENG_EXT, MODE_BYP_EXT: begin
                g.loop_en = 1'b1;
                g.local_clk_en = 1'b1;
                g.ext_ref_on = 1'b1;
                g.ext_src_on = 1'b1;
                g.int_ref_on = c.int_en;
            end
            MODE_BYP_INT_LP: begin
                g.int_ref_on = 1'b1;
            end
            MODE_BYP_EXT_LP: begin
                g.ext_ref_on = 1'b1;
                g.ext_src_on = 1'b1;
                g.int_ref_on = c.int_en;
            end
            MODE_STOP: begin
                g.main_sel = SRC_LOOP;
                g.loop_ref_int = 1'b0;
                g.int_ref_on = c.int_en && c.int_stop;
                g.int_ref_out_en = c.int_en && c.int_stop;
                g.ext_ref_on = 1'b0;
                g.ext_src_on = c.ext_en && c.ext_stop;
            end
            default: begin
                g.int_ref_on = 1'b1;
            end
        endcase
        return g;
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    fcs_ctrl_t ctrl_q;
    logic [1:0] range_sel_q;
    logic dmx_q;
    logic fine_trim_q;
    logic [4:0] xfer_s1_q;
    logic [4:0] xfer_s2_q;
    logic [1:0] range_st_q;
    logic ref_st_q;
    fcs_mode_t run_q;
    logic in_stop_q;
    logic osc_rdy_q;
    logic [PIN_N-1:0] pin_s1_q;
    logic [PIN_N-1:0] pin_s2_q;
    logic [PIN_N-1:0] pin_s3_q;
    logic [PIN_N-1:0] pin_q;
    logic [1:0] trim_cnt_q;
    logic trim_loaded_q;
    logic [7:0] rdata_q;
    fcs_gate_t gate_q;
    fcs_mode_t mode_q;
    logic [10:0] factor_q;
    logic [3:0] bus_divider_q;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire logic wr_sc = i_wr && (i_addr == REG_SC);
    wire logic wr_c1 = i_wr && (i_addr == REG_CTRL1);
    wire logic wr_c2 = i_wr && (i_addr == REG_CTRL2);
    wire logic [1:0] wr_range = i_wdata[SC_RANGE_LO +: 2];
    wire logic range_wr_ok = wr_sc && !ctrl_q.lp && (wr_range != RANGE_RSVD);
    wire logic [1:0] wr_src = i_wdata[C1_SRC_LO +: 2];
    wire logic [1:0] wr_src_ok = (wr_src == SRC_RSVD) ? SRC_LOOP : wr_src;
    wire logic dbg = pin_q[PIN_DBG];
    // resynced view of the selections written by software
    wire logic [1:0] xsrc = xfer_s2_q[4:3];
    wire logic xref = xfer_s2_q[2];
    wire logic [1:0] xrange = xfer_s2_q[1:0];
    wire fcs_mode_t target = run_mode(xsrc, ctrl_q.lp, dbg, xref);
    wire logic [1:0] target_src = mode_src(target);
    wire logic [1:0] clock_mode_status = mode_src(run_q);
    wire logic loop_avail = (target_src != SRC_LOOP) || pin_q[PIN_LOCK];
    wire logic ext_avail = !uses_ext(target) || pin_q[PIN_EXT];
    wire logic switch_ok = (target_src == clock_mode_status) || (loop_avail && ext_avail);
    wire fcs_mode_t mode_w = in_stop_q ? MODE_STOP : run_q;
    wire logic ext_in_use = ctrl_q.ext_en || uses_ext(run_q);
    wire logic osc_set = ctrl_q.osc_req && ext_in_use && pin_q[PIN_OSC];
    wire logic osc_clr = !ctrl_q.osc_req || !ext_in_use;
    wire logic trim_load = !trim_loaded_q && (trim_cnt_q == TRIM_LOAD_CYC);
    wire logic [7:0] sc_rd = {range_st_q, dmx_q, ref_st_q, clock_mode_status, osc_rdy_q, fine_trim_q};
    wire logic [7:0] c1_rd = {ctrl_q.src_sel, ctrl_q.ref_div, ctrl_q.ref_sel,
                              ctrl_q.int_en, ctrl_q.int_stop};
    wire logic [7:0] c2_rd = {ctrl_q.bus_div, 2'h0, ctrl_q.lp, ctrl_q.osc_req,
                              ctrl_q.ext_en, ctrl_q.ext_stop};
    wire logic [7:0] rd_mux = (i_addr == REG_SC) ? sc_rd :
                              (i_addr == REG_CTRL1) ? c1_rd :
                              (i_addr == REG_CTRL2) ? c2_rd : 8'h00;
    wire logic [PIN_N-1:0] pin_agree = ~(pin_s2_q ^ pin_s3_q);
    // filtered pin value taken at this edge; the strap load needs it without a cycle of lag
    wire logic [PIN_N-1:0] pin_d = (pin_s3_q & pin_agree) | (pin_q & ~pin_agree);
    wire logic [PIN_N-1:0] pins = {i_loop_locked, i_ext_ref_ok, i_osc_init_done,
                                   i_debug_active};

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            pin_s3_q <= '0;
            pin_q <= '0;
        end else if (i_clk_en) begin
            pin_s1_q <= pins;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_q <= pin_d;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl_q <= '{SRC_LOOP, REF_DIVIDER_RST, 1'b1, 1'b0, 1'b0, BUS_DIVIDER_RST, 1'b0, 1'b0, 1'b0, 1'b0};
            range_sel_q <= RANGE_LOW;
            dmx_q <= 1'b0;
        end else if (i_clk_en) begin
            if (range_wr_ok) begin
                range_sel_q <= wr_range;
            end
            if (wr_sc) begin
                dmx_q <= i_wdata[SC_DMX];
            end
            if (wr_c1) begin
                ctrl_q.src_sel <= wr_src_ok;
                ctrl_q.ref_div <= i_wdata[C1_REF_DIVIDER_LO +: 3];
                ctrl_q.ref_sel <= i_wdata[C1_REFSEL];
                ctrl_q.int_en <= i_wdata[C1_INT_EN];
                ctrl_q.int_stop <= i_wdata[C1_INT_STOP];
            end
            if (wr_c2) begin
                ctrl_q.bus_div <= i_wdata[C2_BUS_DIVIDER_LO +: 2];
                ctrl_q.lp <= i_wdata[C2_LP];
                ctrl_q.osc_req <= i_wdata[C2_OSC_REQ];
                ctrl_q.ext_en <= i_wdata[C2_EXT_EN];
                ctrl_q.ext_stop <= i_wdata[C2_EXT_STOP];
            end
        end
    end

    // fine trim: strap taken once the debug pin filter has settled
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            fine_trim_q <= 1'b0;
            trim_cnt_q <= 2'h0;
            trim_loaded_q <= 1'b0;
        end else if (i_clk_en) begin
            if (!trim_loaded_q) begin
                trim_cnt_q <= trim_cnt_q + 2'h1;
            end
            if (trim_load) begin
                fine_trim_q <= pin_d[PIN_DBG] ? 1'b0 : i_factory_fine_trim;
                trim_loaded_q <= 1'b1;
            end else if (wr_sc) begin
                fine_trim_q <= i_wdata[SC_FINE_TRIM];
            end
        end
    end

    // ----------------------------------------------------------------
    // status resync and mode state
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            xfer_s1_q <= {SRC_LOOP, 1'b1, RANGE_LOW};
            xfer_s2_q <= {SRC_LOOP, 1'b1, RANGE_LOW};
            range_st_q <= RANGE_LOW;
            ref_st_q <= 1'b1;
            run_q <= MODE_ENG_INT;
            in_stop_q <= 1'b0;
            osc_rdy_q <= 1'b0;
        end else if (i_clk_en) begin
            xfer_s1_q <= {ctrl_q.src_sel, ctrl_q.ref_sel, range_sel_q};
            xfer_s2_q <= xfer_s1_q;
            range_st_q <= xrange;
            ref_st_q <= xref;
            in_stop_q <= i_stop_req;
            if (!in_stop_q && switch_ok) begin
                run_q <= target;
            end
            if (osc_set) begin
                osc_rdy_q <= 1'b1;
            end else if (osc_clr) begin
                osc_rdy_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata_q <= 8'h00;
            gate_q <= '0;
            mode_q <= MODE_ENG_INT;
            factor_q <= FACT_LOW;
            bus_divider_q <= BUS_DIVIDER_FACT_RST;
        end else if (i_clk_en) begin
            rdata_q <= i_rd ? rd_mux : 8'h00;
            gate_q <= gate_of(mode_w, ctrl_q);
            mode_q <= mode_w;
            factor_q <= fll_factor(range_st_q, dmx_q);
            bus_divider_q <= 4'(4'h1 << ctrl_q.bus_div);
        end
    end

    assign o_rdata = rdata_q;
    assign o_gate = gate_q;
    assign o_mode = mode_q;
    assign o_range_code = range_st_q;
    assign o_max_freq_finetune = dmx_q;
    assign o_fll_factor = factor_q;
    assign o_fine_trim = fine_trim_q;
    assign o_ref_divider = ctrl_q.ref_div;
    assign o_bus_div_factor = bus_divider_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_range_rsvd_drop:
    assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        i_clk_en && wr_sc && (wr_range == RANGE_RSVD) |=> $stable(range_sel_q))
        else $error("reserved range code was stored");

    a_range_lp_hold:
    assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        i_clk_en && wr_sc && ctrl_q.lp |=> $stable(range_sel_q))
        else $error("range select changed while low power set");

    a_range_status_lag:
    assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        i_clk_en && range_wr_ok && (range_sel_q == range_st_q) && (xrange == range_st_q)
        && (xfer_s1_q[1:0] == range_st_q) |=> $stable(range_st_q) ##1 $stable(range_st_q))
        else $error("range status ahead of resync");

    a_factor_table:
    assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (o_range_code == RANGE_HIGH) && o_max_freq_finetune && i_clk_en
        ##1 ($stable(o_range_code) && $stable(o_max_freq_finetune))
        |-> o_fll_factor == FACT_HIGH_MX)
        else $error("high range tuned factor wrong");

    a_stop_int_ref:
    assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        i_clk_en && in_stop_q |=> !o_gate.loop_en && !o_gate.local_clk_en
        && (o_gate.int_ref_out_en == $past(ctrl_q.int_en && ctrl_q.int_stop)))
        else $error("stop gating of loop or internal ref wrong");

    a_stop_ext_src:
    assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        i_clk_en && in_stop_q |=> o_gate.ext_src_on == $past(ctrl_q.ext_en && ctrl_q.ext_stop))
        else $error("stop gating of external source wrong");

    a_lp_int_gates:
    assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        i_clk_en && (mode_w == MODE_BYP_INT_LP) |=> !o_gate.loop_en && !o_gate.local_clk_en
        && (o_gate.main_sel == SRC_INT))
        else $error("internal low power gating wrong");

    a_switch_hold:
    assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        i_clk_en && !in_stop_q && (target_src != clock_mode_status) && !(loop_avail && ext_avail)
        |=> $stable(run_q))
        else $error("switched to an unavailable clock");

    a_osc_clear:
    assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        i_clk_en && !ctrl_q.osc_req |=> !osc_rdy_q)
        else $error("oscillator ready held without request");

    a_trim_debug:
    assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        i_clk_en && trim_load && pin_d[PIN_DBG] |=> !o_fine_trim && trim_loaded_q)
        else $error("fine trim not zero in debug");

    a_read_window:
    assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        i_clk_en && !i_rd |=> o_rdata == 8'h00)
        else $error("read data outside its cycle");
endmodule

/* rtl/fcs_pkg.sv */
// Purpose: constants and types for the loop clock source mode control
// Assumes: 8-bit register port, one 20 MHz clock
// Notes: register offsets and the two control registers are local choices
package fcs_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [1:0] REG_SC = 2'h0;
    localparam logic [1:0] REG_CTRL1 = 2'h1;
    localparam logic [1:0] REG_CTRL2 = 2'h2;
    localparam int SC_RANGE_LO = 6;
    localparam int SC_DMX = 5;
    localparam int SC_REF_ST = 4;
    localparam int SC_CLOCK_MODE_STATUS_LO = 2;
    localparam int SC_OSC = 1;
    localparam int SC_FINE_TRIM = 0;
    localparam int C1_SRC_LO = 6;
    localparam int C1_REF_DIVIDER_LO = 3;
    localparam int C1_REFSEL = 2;
    localparam int C1_INT_EN = 1;
    localparam int C1_INT_STOP = 0;
    localparam int C2_BUS_DIVIDER_LO = 6;
    localparam int C2_LP = 3;
    localparam int C2_OSC_REQ = 2;
    localparam int C2_EXT_EN = 1;
    localparam int C2_EXT_STOP = 0;
    // ----------------------------------------------------------------
    // encodings and reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] RANGE_LOW = 2'h0;
    localparam logic [1:0] RANGE_MID = 2'h1;
    localparam logic [1:0] RANGE_HIGH = 2'h2;
    localparam logic [1:0] RANGE_RSVD = 2'h3;
    localparam logic [1:0] SRC_LOOP = 2'h0;
    localparam logic [1:0] SRC_INT = 2'h1;
    localparam logic [1:0] SRC_EXT = 2'h2;
    localparam logic [1:0] SRC_RSVD = 2'h3;
    localparam logic [1:0] BUS_DIVIDER_RST = 2'h1;
    localparam logic [2:0] REF_DIVIDER_RST = 3'h0;
    localparam logic [10:0] FACT_LOW = 11'h200;
    localparam logic [10:0] FACT_LOW_MX = 11'h260;
    localparam logic [10:0] FACT_MID = 11'h400;
    localparam logic [10:0] FACT_MID_MX = 11'h4C0;
    localparam logic [10:0] FACT_HIGH = 11'h600;
    localparam logic [10:0] FACT_HIGH_MX = 11'h720;
    localparam logic [3:0] BUS_DIVIDER_FACT_RST = 4'h2;
    // pin synchroniser lanes
    localparam int PIN_N = 4;
    localparam int PIN_DBG = 0;
    localparam int PIN_OSC = 1;
    localparam int PIN_EXT = 2;
    localparam int PIN_LOCK = 3;
    // cycles after reset release before the trim strap is taken
    localparam logic [1:0] TRIM_LOAD_CYC = 2'h3;

    typedef enum logic [2:0] {
        MODE_ENG_INT,
        MODE_ENG_EXT,
        MODE_BYP_INT,
        MODE_BYP_INT_LP,
        MODE_BYP_EXT,
        MODE_BYP_EXT_LP,
        MODE_STOP
    } fcs_mode_t;

    typedef struct packed {
        logic [1:0] main_sel;
        logic loop_en;
        logic loop_ref_int;
        logic local_clk_en;
        logic int_ref_on;
        logic int_ref_out_en;
        logic ext_ref_on;
        logic ext_src_on;
    } fcs_gate_t;

    typedef struct packed {
        logic [1:0] src_sel;
        logic [2:0] ref_div;
        logic ref_sel;
        logic int_en;
        logic int_stop;
        logic [1:0] bus_div;
        logic lp;
        logic osc_req;
        logic ext_en;
        logic ext_stop;
    } fcs_ctrl_t;
endpackage

/* bench/fcs_ext_osc_model.sv */
// Purpose: external oscillator seen from the mode control block
// Assumes: oscillator powers up when the request is high
// Notes: init done and usable reference rise together after INIT_CYC cycles
`timescale 1ns/1ns
module fcs_ext_osc_model #(
    parameter int INIT_CYC = 30
) (
    input wire logic i_clk, // block clock
    input wire logic i_nrst, // async reset, active low
    input wire logic i_req, // oscillator requested
    output logic o_init_done, // start-up cycles complete
    output logic o_ref_ok // divided reference usable
);
    int cnt_q;
    // a dropped request restarts the whole start-up
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_q <= 0;
        end else if (!i_req) begin
            cnt_q <= 0;
        end else if (cnt_q < INIT_CYC) begin
            cnt_q <= cnt_q + 1;
        end
    end
    assign o_init_done = (cnt_q == INIT_CYC);
    assign o_ref_ok = o_init_done;
endmodule

/* bench/fcs_mode_ctrl_tb_top.sv */
// Purpose: register and mode sequence checks for the mode control block
// Assumes: clock enable and loop lock held high
// Notes: waits are bounded; a timeout counts as a mismatch
`timescale 1ns/1ns
module fcs_mode_ctrl_tb_top;
    import fcs_pkg::*;
    logic clk = 0, nrst = 0, wr = 0, rd = 0, stop = 0, dbg = 0, osc_req = 0;
    logic [1:0] addr = '0;
    logic [7:0] wdata = '0, rdata, d;
    logic init_done, ref_ok;
    fcs_gate_t gate;
    fcs_mode_t mode;
    logic [1:0] range;
    logic fine, trim;
    logic [10:0] fact;
    logic [2:0] ref_divider;
    logic [3:0] bus_divider;
    int bad_count = 0, checks = 0;
    initial forever #25 clk = ~clk;
    fcs_mode_ctrl uut (.i_ref_clk(clk), .i_nrst(nrst), .i_clk_en(1'b1), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_stop_req(stop),
        .i_debug_active(dbg), .i_osc_init_done(init_done), .i_ext_ref_ok(ref_ok),
        .i_loop_locked(1'b1), .i_factory_fine_trim(1'b1), .o_gate(gate), .o_mode(mode),
        .o_range_code(range), .o_max_freq_finetune(fine), .o_fll_factor(fact),
        .o_fine_trim(trim), .o_ref_divider(ref_divider), .o_bus_div_factor(bus_divider));
    fcs_ext_osc_model osc (.i_clk(clk), .i_nrst(nrst), .i_req(osc_req),
        .o_init_done(init_done), .o_ref_ok(ref_ok));
    // ------------------------------------------------------------
    // bus and check tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [10:0] exp, input logic [10:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wreg(input logic [1:0] a, input logic [7:0] v);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rreg(input logic [1:0] a, output logic [7:0] v);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wait_mode(input fcs_mode_t m);
        int i;
        for (i = 0; i < 60 && mode !== m; i++) cyc(1);
        if (mode !== m) begin
            chk("mode timeout", 11'(m), 11'(mode));
            final_report();
        end
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        cyc(12);
        nrst <= 1'b1;
        cyc(8);
        rreg(REG_SC, d); chk("sc reset", 8'h11, d);
        rreg(REG_CTRL1, d); chk("ctrl1 reset", 8'h04, d);
        rreg(REG_CTRL2, d); chk("ctrl2 reset", 8'h40, d);
        rreg(2'h3, d); chk("unmapped", 8'h00, d);
        chk("bus div reset", 4'h2, bus_divider);
        chk("factor reset", 11'h200, fact);
        chk("fei gate", 9'h078, gate);
        wreg(REG_CTRL1, 8'hC4); rreg(REG_CTRL1, d); chk("src rsvd", 8'h04, d);
        $display("test reset done");
        wreg(REG_SC, 8'h40); chk("range not yet", 2'h0, range);
        cyc(6); rreg(REG_SC, d); chk("sc mid", 8'h50, d);
        chk("factor mid", 11'h4C0 - 11'hC0, fact);
        wreg(REG_SC, 8'hE1); cyc(6); rreg(REG_SC, d); chk("sc rsvd", 8'h71, d);
        chk("factor mid mx", 11'h4C0, fact);
        chk("fine trim", 1'b1, trim);
        wreg(REG_SC, 8'h80); cyc(6); rreg(REG_SC, d); chk("sc high", 8'h90, d);
        chk("factor high", 11'h600, fact);
        wreg(REG_SC, 8'hA0); cyc(6); chk("factor high mx", 11'h720, fact);
        wreg(REG_CTRL2, 8'h48); wreg(REG_SC, 8'h00); cyc(6);
        rreg(REG_SC, d); chk("range lp", 2'h2, d[7:6]);
        $display("test range done");
        wreg(REG_CTRL1, 8'h44); wait_mode(MODE_BYP_INT_LP); cyc(1);
        chk("bypass_internal_lowpower_mode gate", {SRC_INT, 3'h0}, {gate.main_sel, gate.loop_en,
            gate.local_clk_en, gate.ext_src_on});
        rreg(REG_SC, d); chk("clock mode", 2'h1, d[3:2]);
        wreg(REG_CTRL2, 8'h40); wait_mode(MODE_BYP_INT); cyc(1);
        chk("fbi gate", 2'h3, {gate.loop_en, gate.local_clk_en});
        wreg(REG_CTRL1, 8'h47); cyc(6);
        stop <= 1'b1; wait_mode(MODE_STOP); cyc(1);
        chk("stop gate", 3'h1, {gate.local_clk_en, gate.loop_en, gate.int_ref_out_en});
        stop <= 1'b0; wait_mode(MODE_BYP_INT);
        $display("test internal done");
        wreg(REG_CTRL2, 8'hC7); osc_req <= 1'b1; cyc(1);
        chk("bus div 8", 4'h8, bus_divider);
        wreg(REG_CTRL1, 8'h80); cyc(8);
        chk("held source", 11'(MODE_BYP_INT), 11'(mode));
        wait_mode(MODE_BYP_EXT); cyc(1);
        chk("fbe main", SRC_EXT, gate.main_sel);
        rreg(REG_SC, d); chk("osc ready", 3'h5, d[3:1]);
        chk("ref status", 1'b0, d[4]);
        wreg(REG_CTRL2, 8'hCF); wait_mode(MODE_BYP_EXT_LP); cyc(1);
        chk("bypass_external_lowpower_mode gate", 3'h1, {gate.loop_en, gate.local_clk_en, gate.ext_src_on});
        wreg(REG_CTRL1, 8'h00); wait_mode(MODE_ENG_EXT); cyc(1);
        chk("fee gate", 4'h2, {gate.main_sel, gate.loop_en, gate.loop_ref_int});
        stop <= 1'b1; wait_mode(MODE_STOP); cyc(1);
        chk("ext in stop", 1'b1, gate.ext_src_on);
        $display("test external done");
        stop <= 1'b0; dbg <= 1'b1; nrst <= 1'b0; cyc(2);
        nrst <= 1'b1; cyc(8);
        rreg(REG_SC, d); chk("sc debug reset", 8'h10, d);
        chk("trim debug", 1'b0, trim);
        $display("test debug reset done");
        final_report();
    end
endmodule
